// ---- core/cie_cfg.svh ----
/*
  cie_cfg.svh: register offsets, field positions, reset values and
  error thresholds of the interrupt and error-flag block.
  assumes: included by bare name wherever these numbers are needed.
*/
`ifndef CIE_CFG_SVH
`define CIE_CFG_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define CIE_ADDR_ENABLE 8'h28
`define CIE_ADDR_FLAG 8'h29
`define CIE_ADDR_STATUS 8'h2E
`define CIE_ADDR_ERRFLAG 8'h2D

// ------------------------------------------------------------
// source bit positions (enable and flag registers)
// ------------------------------------------------------------
`define CIE_SRC_RX0 0
`define CIE_SRC_RX1 1
`define CIE_SRC_TX0 2
`define CIE_SRC_TX1 3
`define CIE_SRC_TX2 4
`define CIE_SRC_ERR 5
`define CIE_SRC_WAK 6
`define CIE_SRC_MERR 7

// ------------------------------------------------------------
// error flag register bit positions
// ------------------------------------------------------------
`define CIE_EF_ANY_WARNING_FLAG 0
`define CIE_EF_RX_WARNING_FLAG 1
`define CIE_EF_TX_WARNING_FLAG 2
`define CIE_EF_RX_PASSIVE_FLAG 3
`define CIE_EF_TX_PASSIVE_FLAG 4
`define CIE_EF_BOFF 5
`define CIE_EF_OVR0 6
`define CIE_EF_OVR1 7
`define CIE_EF_WMASK 8'hC0

// ------------------------------------------------------------
// status register field, reset value, thresholds
// ------------------------------------------------------------
`define CIE_CODE_LSB 1
`define CIE_RST_BYTE 8'h00
`define CIE_PASSIVE_LIMIT 8'h80
`define CIE_WARNING_LIMIT 8'h60

`endif

// ---- core/cie_pkg.sv ----
/*
  cie_pkg: types shared by the interrupt and error-flag block.
  assumes: compiled before every module that imports it.
*/
package cie_pkg;

  // one register byte
  typedef logic [7:0] cie_byte_t;

  // pending-source code, lower value wins
  typedef enum logic [2:0] {
    cie_code_none = 3'b000,
    cie_code_err = 3'b001,
    cie_code_wak = 3'b010,
    cie_code_tx0 = 3'b011,
    cie_code_tx1 = 3'b100,
    cie_code_tx2 = 3'b101,
    cie_code_rx0 = 3'b110,
    cie_code_rx1 = 3'b111
  } cie_code_t;

endpackage

// ---- core/cie_err_state.sv ----
/*
  cie_err_state: error-state flags derived from the error counters.
  assumes: counters come from logic on the same clock, no sync needed.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cie_cfg.svh"

module cie_err_state
  import cie_pkg::*;
(
  input wire logic i_ref_clk, // system clock
  input wire logic i_rst_b, // sync reset, active low
  input wire logic [7:0] i_tec, // transmit error count
  input wire logic [7:0] i_rec, // receive error count
  input wire logic i_tec_ovf, // transmit count at or above 256
  output logic [5:0] o_state, // boff,tx_passive_flag,rx_passive_flag,tx_warning_flag,rx_warning_flag,any_warning_flag
  output logic o_change // pulse: some state flag moved
);

  // ------------------------------------------------------------
  // threshold compare
  // ------------------------------------------------------------
  logic [5:0] next_state; // flags one cycle ahead

  always_comb begin
    next_state[5] = i_tec_ovf;
    next_state[4] = (i_tec >= `CIE_PASSIVE_LIMIT);
    next_state[3] = (i_rec >= `CIE_PASSIVE_LIMIT);
    next_state[2] = (i_tec >= `CIE_WARNING_LIMIT);
    next_state[1] = (i_rec >= `CIE_WARNING_LIMIT);
    // either count high keeps the combined flag up
    next_state[0] = next_state[2] | next_state[1];
  end

  // ------------------------------------------------------------
  // flag registers and change pulse
  // ------------------------------------------------------------
  // change compares against held value, so reset state never fires
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_state <= 6'h00;
      o_change <= 1'b0;
    end else begin
      o_state <= next_state;
      o_change <= (next_state != o_state);
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_tx_passive;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      1'b1 |=> (o_state[4] == ($past(i_tec) >= `CIE_PASSIVE_LIMIT));
  endproperty
  a_tx_passive: assert property (p_tx_passive)
    else $error("transmit passive flag wrong");

  property p_any_warn;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      (i_tec < `CIE_WARNING_LIMIT && i_rec >= `CIE_WARNING_LIMIT)
        |=> o_state[0] && o_state[1] && !o_state[2];
  endproperty
  a_any_warn: assert property (p_any_warn)
    else $error("combined warning flag wrong");

  property p_bus_off;
    @(posedge i_ref_clk) disable iff (!i_rst_b)
      $rose(i_tec_ovf) |=> o_state[5] && o_change;
  endproperty
  a_bus_off: assert property (p_bus_off)
    else $error("bus-off flag not raised");

endmodule
`default_nettype wire

// ---- core/cie_top.sv ----
/*
  cie_top: interrupt enables, flags, pending-source code, error flag
  register and the active-low interrupt pin of a CAN controller.
  assumes: the serial command decoder presents one register access per
  cycle as strobes on this port; protocol events arrive as one-cycle
  pulses on the system clock; the bus receive pin is asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cie_cfg.svh"

// Contract
// - eight sources, each enable plus flag bit
// - enabled set flag drives interrupt pin low
// - clear ignored while setting condition persists
// - host may set flags, raising interrupt
// - pin stays low until all enabled cleared
// - code shows highest priority pending source
// - code moves to next source after clear
// - only enabled sources affect the code
// - transmit buffer empty sets its flag
// - receive load after frame end sets flag
// - message error sets message fault flag
// - transmit passive while count at least 128
// - combined warning while either count reaches 96
// - error flag register sits at 2Dh
// - bus-off flagged at transmit count 256
// - accept into full buffer sets overflow
// - overflow or error state change raises error
// - bus activity in sleep sets wakeup, exits
module cie_top
  import cie_pkg::*;
#(
  parameter int ADDR_W = 8 // register address width
)
(
  input wire logic i_ref_clk, // system clock, 50 MHz
  input wire logic i_rst_b, // sync reset, active low
  input wire logic i_reg_wr, // register write strobe
  input wire logic i_reg_bm, // write is a masked bit-modify
  input wire logic i_reg_rd, // register read strobe
  input wire logic [ADDR_W-1:0] i_reg_addr, // register address
  input wire logic [7:0] i_reg_wdata, // write data
  input wire logic [7:0] i_reg_mask, // bit-modify mask
  output logic [7:0] o_reg_rdata, // read data
  input wire logic [2:0] i_tx_empty_evt, // transmit buffer emptied
  input wire logic [1:0] i_rx_accept, // filtered message ready to load
  input wire logic i_msg_error, // error during a message
  input wire logic [7:0] i_tec, // transmit error count
  input wire logic [7:0] i_rec, // receive error count
  input wire logic i_tec_ovf, // transmit count at or above 256
  input wire logic i_sleep, // device is asleep
  input wire logic i_bus_rx, // bus receive pin, async
  output logic o_irq_b, // interrupt pin, active low
  output logic [2:0] o_pending_code, // highest pending source
  output logic [1:0] o_rx_load, // pulse: load receive buffer
  output logic o_wake_exit // pulse: leave sleep
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  if (ADDR_W < 6 || ADDR_W > 8) begin : g_bad_addr
    $error("ADDR_W must be 6 to 8");
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // plain write replaces; bit-modify touches masked bits only
  function automatic cie_byte_t cie_merge(input cie_byte_t old,
                                         input cie_byte_t data,
                                         input cie_byte_t mask,
                                         input logic bm);
    cie_merge = bm ? ((old & ~mask) | (data & mask)) : data;
  endfunction

  function automatic logic cie_hit(input logic [ADDR_W-1:0] a,
                                   input cie_byte_t reg_addr);
    cie_hit = (a == reg_addr[ADDR_W-1:0]);
  endfunction

  // fixed priority, error first, second receive buffer last
  function automatic cie_code_t cie_prio(input cie_byte_t p);
    if (p[`CIE_SRC_ERR]) cie_prio = cie_code_err;
    else if (p[`CIE_SRC_WAK]) cie_prio = cie_code_wak;
    else if (p[`CIE_SRC_TX0]) cie_prio = cie_code_tx0;
    else if (p[`CIE_SRC_TX1]) cie_prio = cie_code_tx1;
    else if (p[`CIE_SRC_TX2]) cie_prio = cie_code_tx2;
    else if (p[`CIE_SRC_RX0]) cie_prio = cie_code_rx0;
    else if (p[`CIE_SRC_RX1]) cie_prio = cie_code_rx1;
    else cie_prio = cie_code_none;
  endfunction

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  cie_byte_t irq_enable_reg; // one enable per source
  cie_byte_t irq_flag_reg; // one flag per source
  logic [1:0] rxbuf_overflow_flag; // per receive buffer
  logic [5:0] err_state; // boff,tx_passive_flag,rx_passive_flag,tx_warning_flag,rx_warning_flag,any_warning_flag
  logic err_change; // pulse from error-state logic
  cie_byte_t error_flag_status; // error flag register view
  cie_byte_t hw_set; // hardware set terms this cycle
  cie_byte_t pend; // enabled and pending
  cie_byte_t next_flag; // flag register next value
  logic [1:0] ovf_evt; // accept while buffer still full
  logic wr_en_hit; // write to enable register
  logic wr_flag_hit; // write to flag register
  logic wr_ef_hit; // write to error flag register
  cie_byte_t ef_merged; // error flag register as a host write would leave it
  logic rx_s1; // pin sync stage 1
  logic rx_s2; // pin sync stage 2
  logic rx_s3; // pin sync stage 3
  logic rx_level; // agreed bus level
  logic bus_activity; // agreed fall to dominant
  logic wake_evt; // wakeup event this cycle

  assign wr_en_hit = i_reg_wr && cie_hit(i_reg_addr, `CIE_ADDR_ENABLE);
  assign wr_flag_hit = i_reg_wr && cie_hit(i_reg_addr, `CIE_ADDR_FLAG);
  assign wr_ef_hit = i_reg_wr && cie_hit(i_reg_addr, `CIE_ADDR_ERRFLAG);
  assign pend = irq_flag_reg & irq_enable_reg;
  assign ef_merged = cie_merge(error_flag_status, i_reg_wdata, i_reg_mask, i_reg_bm);

  // ------------------------------------------------------------
  // error-state flags
  // ------------------------------------------------------------
  cie_err_state u_err_state (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_tec(i_tec),
    .i_rec(i_rec),
    .i_tec_ovf(i_tec_ovf),
    .o_state(err_state),
    .o_change(err_change)
  );

  // ------------------------------------------------------------
  // bus pin synchroniser and activity detect
  // ------------------------------------------------------------
  // a change counts only once stages two and three agree
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_s3 <= 1'b1;
      rx_level <= 1'b1;
    end else begin
      rx_s1 <= i_bus_rx;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      if (rx_s2 == rx_s3) begin
        rx_level <= rx_s3;
      end
    end
  end

  // dominant edge seen while idle recessive level was held
  assign bus_activity = (rx_s2 == rx_s3) && !rx_s3 && rx_level;
  assign wake_evt = i_sleep && bus_activity && irq_enable_reg[`CIE_SRC_WAK];

  // ------------------------------------------------------------
  // hardware set terms
  // ------------------------------------------------------------
  // a buffer still flagged full cannot take the new message
  assign ovf_evt = i_rx_accept & {irq_flag_reg[`CIE_SRC_RX1],
                                  irq_flag_reg[`CIE_SRC_RX0]};

  always_comb begin
    hw_set = `CIE_RST_BYTE;
    hw_set[`CIE_SRC_RX0] = i_rx_accept[0] && !ovf_evt[0];
    hw_set[`CIE_SRC_RX1] = i_rx_accept[1] && !ovf_evt[1];
    hw_set[`CIE_SRC_TX0] = i_tx_empty_evt[0];
    hw_set[`CIE_SRC_TX1] = i_tx_empty_evt[1];
    hw_set[`CIE_SRC_TX2] = i_tx_empty_evt[2];
    hw_set[`CIE_SRC_ERR] = err_change || (|ovf_evt);
    hw_set[`CIE_SRC_WAK] = wake_evt;
    hw_set[`CIE_SRC_MERR] = i_msg_error;
  end

  // host value first, then hardware sets on top so they win
  always_comb begin
    next_flag = irq_flag_reg;
    if (wr_flag_hit) begin
      next_flag = cie_merge(irq_flag_reg, i_reg_wdata, i_reg_mask, i_reg_bm);
    end
    next_flag = next_flag | hw_set;
  end

  // ------------------------------------------------------------
  // enable register
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      irq_enable_reg <= `CIE_RST_BYTE;
    end else if (wr_en_hit) begin
      irq_enable_reg <= cie_merge(irq_enable_reg, i_reg_wdata, i_reg_mask, i_reg_bm);
    end
  end

  // ------------------------------------------------------------
  // flag register
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      irq_flag_reg <= `CIE_RST_BYTE;
    end else begin
      irq_flag_reg <= next_flag;
    end
  end

  // ------------------------------------------------------------
  // overflow flags
  // ------------------------------------------------------------
  // sticky until host clears; a new overflow beats the clear
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      rxbuf_overflow_flag <= 2'b00;
    end else if (wr_ef_hit) begin
      rxbuf_overflow_flag <= ovf_evt | ef_merged[`CIE_EF_OVR1:`CIE_EF_OVR0];
    end else begin
      rxbuf_overflow_flag <= rxbuf_overflow_flag | ovf_evt;
    end
  end

  always_comb begin
    error_flag_status = `CIE_RST_BYTE;
    error_flag_status[`CIE_EF_OVR1:`CIE_EF_OVR0] = rxbuf_overflow_flag;
    error_flag_status[`CIE_EF_BOFF:`CIE_EF_ANY_WARNING_FLAG] = err_state;
  end

  // ------------------------------------------------------------
  // interrupt pin, code, and event outputs
  // ------------------------------------------------------------
  // pin lags the flag register by one cycle, code likewise
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_irq_b <= 1'b1;
      o_pending_code <= cie_code_none;
      o_rx_load <= 2'b00;
      o_wake_exit <= 1'b0;
    end else begin
      o_irq_b <= ~(|pend);
      o_pending_code <= cie_prio(pend);
      o_rx_load <= i_rx_accept & ~ovf_evt;
      o_wake_exit <= wake_evt;
    end
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  // unmapped addresses read zero; data holds between reads
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      o_reg_rdata <= `CIE_RST_BYTE;
    end else if (i_reg_rd) begin
      if (cie_hit(i_reg_addr, `CIE_ADDR_ENABLE)) begin
        o_reg_rdata <= irq_enable_reg;
      end else if (cie_hit(i_reg_addr, `CIE_ADDR_FLAG)) begin
        o_reg_rdata <= irq_flag_reg;
      end else if (cie_hit(i_reg_addr, `CIE_ADDR_ERRFLAG)) begin
        o_reg_rdata <= error_flag_status;
      end else if (cie_hit(i_reg_addr, `CIE_ADDR_STATUS)) begin
        o_reg_rdata <= `CIE_RST_BYTE;
        o_reg_rdata[`CIE_CODE_LSB +: 3] <= o_pending_code;
      end else begin
        o_reg_rdata <= `CIE_RST_BYTE;
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  property p_irq_low;
    (|pend) |=> !o_irq_b;
  endproperty
  a_irq_low: assert property (p_irq_low)
    else $error("interrupt pin not low");

  property p_irq_release;
    (pend == 8'h00) |=> o_irq_b;
  endproperty
  a_irq_release: assert property (p_irq_release)
    else $error("interrupt pin low with nothing pending");

  property p_clear_blocked;
    wr_flag_hit && !i_reg_bm && !i_reg_wdata[`CIE_SRC_TX0] && i_tx_empty_evt[0]
      |=> irq_flag_reg[`CIE_SRC_TX0];
  endproperty
  a_clear_blocked: assert property (p_clear_blocked)
    else $error("clear won over set");

  sequence s_host_set;
    wr_flag_hit && !i_reg_bm && i_reg_wdata[`CIE_SRC_RX0] &&
      irq_enable_reg[`CIE_SRC_RX0] && !wr_en_hit;
  endsequence
  property p_host_set;
    s_host_set |=> irq_flag_reg[`CIE_SRC_RX0] ##1 !o_irq_b;
  endproperty
  a_host_set: assert property (p_host_set)
    else $error("host set gave no interrupt");

  property p_code_err;
    pend[`CIE_SRC_ERR] |=> (o_pending_code == cie_code_err);
  endproperty
  a_code_err: assert property (p_code_err)
    else $error("error source not at top");

  property p_code_next;
    $fell(pend[`CIE_SRC_ERR]) && !pend[`CIE_SRC_WAK] && pend[`CIE_SRC_TX0]
      |=> (o_pending_code == cie_code_tx0);
  endproperty
  a_code_next: assert property (p_code_next)
    else $error("code did not move to next source");

  property p_code_none;
    (pend == 8'h00) && (irq_flag_reg != 8'h00) |=> (o_pending_code == cie_code_none);
  endproperty
  a_code_none: assert property (p_code_none)
    else $error("disabled flag shows in code");

  property p_tx_empty;
    i_tx_empty_evt[2] |=> irq_flag_reg[`CIE_SRC_TX2];
  endproperty
  a_tx_empty: assert property (p_tx_empty)
    else $error("transmit empty flag missing");

  property p_rx_full;
    i_rx_accept[0] && !irq_flag_reg[`CIE_SRC_RX0]
      |=> irq_flag_reg[`CIE_SRC_RX0] && o_rx_load[0] && !$rose(rxbuf_overflow_flag[0]);
  endproperty
  a_rx_full: assert property (p_rx_full)
    else $error("receive full flag or load missing");

  property p_msg_err;
    i_msg_error |=> irq_flag_reg[`CIE_SRC_MERR];
  endproperty
  a_msg_err: assert property (p_msg_err)
    else $error("message fault flag missing");

  property p_overflow;
    i_rx_accept[1] && irq_flag_reg[`CIE_SRC_RX1]
      |=> rxbuf_overflow_flag[1] && irq_flag_reg[`CIE_SRC_ERR] && !o_rx_load[1];
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("overflow not flagged");

  property p_err_irq;
    err_change |=> irq_flag_reg[`CIE_SRC_ERR];
  endproperty
  a_err_irq: assert property (p_err_irq)
    else $error("error state change not flagged");

  property p_wake;
    wake_evt |=> irq_flag_reg[`CIE_SRC_WAK] && o_wake_exit;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wakeup not flagged");

endmodule
`default_nettype wire

// ---- sim/cie_host_model.sv ----
/*
  cie_host_model: host controller on the register port of cie_top.
  assumes: one access per call, strobes launched 1 ns after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none

module cie_host_model
  import cie_pkg::*;
(
  input wire logic i_ref_clk, // system clock
  input wire logic [7:0] i_reg_rdata, // read data from the block
  output logic o_reg_wr, // write strobe
  output logic o_reg_bm, // masked bit-modify qualifier
  output logic o_reg_rd, // read strobe
  output logic [7:0] o_reg_addr, // register address
  output logic [7:0] o_reg_wdata, // write data
  output logic [7:0] o_reg_mask // bit-modify mask
);
  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  // idle bus at time zero
  initial begin
    {o_reg_wr, o_reg_bm, o_reg_rd} = 3'h0;
    {o_reg_addr, o_reg_wdata, o_reg_mask} = 24'h000000;
  end

  // one strobe cycle; released lines flip so stale values never look valid
  task automatic access(input logic wr, bm, rd, input cie_byte_t a, d, m);
    @(posedge i_ref_clk);
    #1;
    {o_reg_wr, o_reg_bm, o_reg_rd} = {wr, bm, rd};
    {o_reg_addr, o_reg_wdata, o_reg_mask} = {a, d, m};
    @(posedge i_ref_clk);
    #1;
    {o_reg_wr, o_reg_bm, o_reg_rd} = 3'h0;
    {o_reg_addr, o_reg_wdata, o_reg_mask} = ~{a, d, m};
  endtask

  // plain write; writing zero clears buffer flags
  task automatic wr_reg(input cie_byte_t a, d);
    access(1'b1, 1'b0, 1'b0, a, d, 8'hFF);
  endtask

  // masked clear keeps flags that change during the access
  task automatic bm_reg(input cie_byte_t a, m, d);
    access(1'b1, 1'b1, 1'b0, a, d, m);
  endtask

  // read; data is taken an edge after the strobe, it holds until next read
  task automatic rd_reg(input cie_byte_t a, output cie_byte_t d);
    access(1'b0, 1'b0, 1'b1, a, 8'h00, 8'h00);
    @(posedge i_ref_clk);
    #1;
    d = i_reg_rdata;
  endtask
endmodule

`default_nettype wire

// ---- sim/cie_top_tb.sv ----
/*
  cie_top_tb: self-checking bench for cie_top driven through the host model.
  assumes: cie_pkg, cie_cfg.svh and the host model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cie_cfg.svh"

module cie_top_tb
  import cie_pkg::*;
;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clk = 1'b0, rst_b = 1'b0, sleep = 1'b0, bus_rx = 1'b1; // bus idles recessive
  logic msg_err = 1'b0, tec_ovf = 1'b0;
  logic [2:0] tx_evt = 3'h0, code;
  logic [1:0] rx_acc = 2'h0, rx_load;
  logic [7:0] tx_error_count = 8'h00, rx_error_count = 8'h00, reg_addr, reg_wdata, reg_mask, rdata;
  logic reg_wr, reg_bm, reg_rd, irq_b, wake;
  int err_total = 0, checks = 0, cyc = 0, loads = 0, wakes = 0;
  cie_byte_t rv, ev;
  // expected code per source bit, bit 0 first
  cie_code_t exp_code[8] = '{cie_code_rx0, cie_code_rx1, cie_code_tx0, cie_code_tx1,
    cie_code_tx2, cie_code_err, cie_code_wak, cie_code_none};
  // counts {tec, rec, overflow, expected error flags}
  logic [24:0] etab[9] = '{{8'h5F, 8'h00, 1'b0, 8'h00}, {8'h60, 8'h00, 1'b0, 8'h05},
    {8'h00, 8'h60, 1'b0, 8'h03}, {8'h7F, 8'h00, 1'b0, 8'h05}, {8'h80, 8'h00, 1'b0, 8'h15},
    {8'h00, 8'h80, 1'b0, 8'h0B}, {8'h82, 8'h80, 1'b0, 8'h1F}, {8'hFF, 8'h00, 1'b1, 8'h35},
    {8'h00, 8'h00, 1'b0, 8'h00}};
  cie_byte_t regs[5] = '{`CIE_ADDR_ENABLE, `CIE_ADDR_FLAG, `CIE_ADDR_ERRFLAG,
    `CIE_ADDR_STATUS, 8'h00};

  always #10 clk = ~clk; // 50 MHz

  cie_top dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_reg_wr(reg_wr), .i_reg_bm(reg_bm),
    .i_reg_rd(reg_rd), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
    .i_reg_mask(reg_mask), .o_reg_rdata(rdata), .i_tx_empty_evt(tx_evt),
    .i_rx_accept(rx_acc), .i_msg_error(msg_err), .i_tec(tx_error_count), .i_rec(rx_error_count),
    .i_tec_ovf(tec_ovf), .i_sleep(sleep), .i_bus_rx(bus_rx), .o_irq_b(irq_b),
    .o_pending_code(code), .o_rx_load(rx_load), .o_wake_exit(wake));

  cie_host_model host (.i_ref_clk(clk), .i_reg_rdata(rdata), .o_reg_wr(reg_wr),
    .o_reg_bm(reg_bm), .o_reg_rd(reg_rd), .o_reg_addr(reg_addr),
    .o_reg_wdata(reg_wdata), .o_reg_mask(reg_mask));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input cie_byte_t got, exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input cie_byte_t a, exp);
    host.rd_reg(a, rv);
    chk(rv, exp);
  endtask

  // settle n edges, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // pin and code packed as {0000, code, irq_b}
  task automatic pin(input cie_byte_t exp);
    tick(2);
    chk({4'h0, code, irq_b}, exp);
  endtask

  task automatic wrap_up();
    if (err_total == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // pulse counters and hang guard; a run needs well under 2000 cycles
  always @(posedge clk) begin
    cyc++;
    if (rx_load[0] === 1'b1) loads++;
    if (rx_load[1] === 1'b1) loads++;
    if (wake === 1'b1) wakes++;
    if (cyc == 5000) begin
      err_total++;
      wrap_up();
    end
  end

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    #1 rst_b = 1'b1;
    foreach (regs[i]) rdchk(regs[i], 8'h00);
    chk({7'h00, irq_b}, 8'h01);
    host.wr_reg(`CIE_ADDR_ENABLE, 8'hFF);
    rdchk(`CIE_ADDR_ENABLE, 8'hFF);
    // each source alone, cleared with data bits set outside the mask
    for (int b = 0; b < 8; b++) begin
      host.wr_reg(`CIE_ADDR_FLAG, 8'h01 << b);
      pin({4'h0, exp_code[b], 1'b0});
      host.bm_reg(`CIE_ADDR_FLAG, 8'h01 << b, ~(8'h01 << b));
      pin(8'h01);
    end
    // three pending at once, peeled off in priority order
    host.wr_reg(`CIE_ADDR_FLAG, 8'h26);
    pin(8'h02);
    rdchk(`CIE_ADDR_STATUS, 8'h02);
    host.bm_reg(`CIE_ADDR_FLAG, 8'h20, 8'hDF);
    pin(8'h06);
    host.bm_reg(`CIE_ADDR_FLAG, 8'h04, 8'hFB);
    pin(8'h0E);
    host.bm_reg(`CIE_ADDR_FLAG, 8'h02, 8'hFD);
    pin(8'h01);
    // disabled source stays out of pin and code
    host.wr_reg(`CIE_ADDR_ENABLE, 8'hFE);
    host.wr_reg(`CIE_ADDR_FLAG, 8'h01);
    pin(8'h01);
    host.wr_reg(`CIE_ADDR_ENABLE, 8'hFF);
    pin(8'h0C);
    host.wr_reg(`CIE_ADDR_FLAG, 8'h00);
    // hardware events in one cycle
    {tx_evt, rx_acc, msg_err} = 6'b110111;
    tick(1);
    {tx_evt, rx_acc, msg_err} = 6'h00;
    tick(2);
    rdchk(`CIE_ADDR_FLAG, 8'h9B);
    chk(8'(loads), 8'h02);
    pin(8'h08);
    // second message for full buffers overflows instead of loading
    rx_acc = 2'b11;
    tick(1);
    rx_acc = 2'b00;
    tick(3);
    rdchk(`CIE_ADDR_ERRFLAG, 8'hC0);
    rdchk(`CIE_ADDR_FLAG, 8'hBB);
    chk(8'(loads), 8'h02);
    // clear refused while the empty condition is still present
    tx_evt = 3'b001;
    tick(2);
    host.wr_reg(`CIE_ADDR_FLAG, 8'h00);
    rdchk(`CIE_ADDR_FLAG, 8'h04);
    tx_evt = 3'b000;
    host.wr_reg(`CIE_ADDR_ERRFLAG, 8'h00);
    rdchk(`CIE_ADDR_ERRFLAG, 8'h00);
    // only the overflow bits take writes
    host.wr_reg(`CIE_ADDR_ERRFLAG, 8'hFF);
    rdchk(`CIE_ADDR_ERRFLAG, 8'hC0);
    host.wr_reg(`CIE_ADDR_ERRFLAG, 8'h00);
    host.wr_reg(`CIE_ADDR_FLAG, 8'h00);
    // error counter thresholds on both sides of each limit
    foreach (etab[i]) begin
      {tx_error_count, rx_error_count, tec_ovf, ev} = etab[i];
      tick(3);
      rdchk(`CIE_ADDR_ERRFLAG, ev);
    end
    rdchk(`CIE_ADDR_FLAG, 8'h20);
    pin(8'h02);
    // dominant edge on the bus while asleep
    host.wr_reg(`CIE_ADDR_FLAG, 8'h00);
    sleep = 1'b1;
    tick(2);
    bus_rx = 1'b0;
    for (int i = 0; i < 12 && wakes == 0; i++) tick(1);
    chk(8'(wakes), 8'h01);
    rdchk(`CIE_ADDR_FLAG, 8'h40);
    pin(8'h04);
    {bus_rx, sleep} = 2'b10;
    wrap_up();
  end
endmodule

`default_nettype wire
